// ### hdl/cck_console.sv
// console key control: operator keys to processor actions
`timescale 1ns/1ps
`default_nettype none
module cck_console #(
   parameter int REPEAT_CYC = cck_pkg::REPEAT_CYCLES
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [13:0] i_keys,
   input  wire logic        i_repeat,
   input  wire logic [35:0] i_data_switch_reg,
   input  wire logic [17:0] i_address_switch_reg,
   input  wire logic [2:0]  i_reader_chan,
   input  wire logic        i_inst_done,
   input  wire logic        i_fetch,
   input  wire logic [17:0] i_fetch_addr,
   input  wire logic        i_mem_call,
   input  wire logic [17:0] i_mem_addr,
   input  wire logic        i_mem_write,
   input  wire logic [35:0] i_mem_wdata,
   input  wire logic        i_mem_done,
   input  wire logic [35:0] i_mem_rdata,
   input  wire logic [17:0] i_ma,
   input  wire logic        i_key_mem_done,
   input  wire logic        i_input_word_instr,
   input  wire logic        i_interrupt_system_enabled,
   input  wire logic        i_pi_on_wr,
   input  wire logic [6:0]  i_pi_on_wdata,
   input  wire logic [6:0]  i_pi_prog_req,
   input  wire logic [6:0]  i_pi_dev_req,
   input  wire logic        i_pi_break,
   input  wire logic        i_io_transfer_instr,
   input  wire logic        i_pi_dismiss,
   output logic             o_run,
   output logic             o_start,
   output logic [17:0]      o_start_addr,
   output logic             o_resume,
   output logic             o_single_single_instruction_key,
   output logic [35:0]      o_single_instruction_key_word,
   output logic             o_console_single_instruction_key,
   output logic             o_io_clear,
   output logic             o_bootstrap_mode_flag,
   output logic             o_fast_mem_disable,
   output logic             o_hidden_core_sel,
   output logic             o_memory_break_flag,
   output logic             o_mem_restart,
   output logic             o_read_only_rpw,
   output logic             o_key_mem_req,
   output logic             o_key_write,
   output logic [17:0]      o_key_addr,
   output logic [35:0]      o_key_wdata,
   output logic             o_key_load_ma,
   output logic [35:0]      o_mem_display,
   output logic [35:0]      o_input_word,
   output logic             o_reader_motor,
   output logic             o_reader_brake,
   output logic [6:0]       o_channel_on_bits,
   output logic [6:0]       o_channel_request_bits,
   output logic [6:0]       o_channel_hold_bits,
   output logic [6:0]       o_pi_grant
);
   typedef enum logic [1:0] {CCK_IDLE, CCK_MEM, CCK_SINGLE_INSTRUCTION_KEY} cck_state_t;

   cck_state_t state;
   logic [13:0] lvl;
   logic [13:0] trg;
   logic [35:0] ds_meta;
   logic [35:0] ds;
   logic [17:0] mas_meta;
   logic [17:0] address_switch_reg;
   logic        idle;
   logic        go_start;
   logic        go_resume;
   logic        go_single_instruction_key;
   logic        go_ioclr;
   logic        go_mem;
   logic        mem_wr;
   logic [17:0] mem_addr;
   logic        mem_restart_key;
   logic        halt_edge;
   logic [6:0]  rdr_req;

   cck_key_sync #(
      .N   (cck_pkg::NKEYS),
      .REP (REPEAT_CYC)
   ) u_keys (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_keys    (i_keys),
      .i_repeat  (i_repeat),
      .o_level   (lvl),
      .o_trig    (trg)
   );

   // switches are slow levels; two stages are enough to settle them
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ds_meta <= '0;
         ds <= '0;
         mas_meta <= '0;
         address_switch_reg <= '0;
      end else begin
         ds_meta <= i_data_switch_reg;
         ds <= ds_meta;
         mas_meta <= i_address_switch_reg;
         address_switch_reg <= mas_meta;
      end
   end

   assign idle = state == CCK_IDLE;
   assign halt_edge = trg[cck_pkg::K_HALT] && !lvl[cck_pkg::K_RESUME];
   assign go_start = idle && !o_run && (trg[cck_pkg::K_START] || trg[cck_pkg::K_BOOT]); // see R1
   assign go_resume = idle && !o_run && trg[cck_pkg::K_RESUME]; // see R5
   assign go_single_instruction_key = idle && !o_run && trg[cck_pkg::K_SINGLE_INSTRUCTION_KEY]; // see R11
   assign go_ioclr = idle && !o_run && trg[cck_pkg::K_IOCLR]; // see R14

   // next memory key: here keys work any time, following keys only when stopped
   always_comb begin
      go_mem = 1'b0;
      mem_wr = 1'b0;
      mem_addr = address_switch_reg;
      if (idle && trg[cck_pkg::K_DEP]) begin
         go_mem = 1'b1; // see R15
         mem_wr = 1'b1;
      end else if (idle && !o_run && trg[cck_pkg::K_DEPNXT]) begin
         go_mem = 1'b1; // see R16
         mem_wr = 1'b1;
         mem_addr = i_ma + 18'h1;
      end else if (idle && trg[cck_pkg::K_EX]) begin
         go_mem = 1'b1; // see R17
      end else if (idle && !o_run && trg[cck_pkg::K_EXNXT]) begin
         go_mem = 1'b1; // see R17
         mem_addr = i_ma + 18'h1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= CCK_IDLE;
      end else begin
         unique case (state)
            CCK_IDLE: begin
               if (go_mem) begin
                  state <= CCK_MEM;
               end else if (go_single_instruction_key) begin
                  state <= CCK_SINGLE_INSTRUCTION_KEY;
               end
            end
            CCK_MEM: begin
               if (i_key_mem_done) begin
                  state <= CCK_IDLE;
               end
            end
            CCK_SINGLE_INSTRUCTION_KEY: begin
               if (i_inst_done) begin
                  state <= CCK_IDLE; // see R11
               end
            end
         endcase
      end
   end

   // with halt held, resume starts one instruction and run stays clear
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_run <= cck_pkg::RUN_RST;
      end else if (go_start || go_resume) begin
         o_run <= !lvl[cck_pkg::K_HALT]; // see R6
      end else if (halt_edge || lvl[cck_pkg::K_HALT]) begin
         o_run <= 1'b0; // see R4
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_start <= 1'b0;
         o_resume <= 1'b0;
         o_single_single_instruction_key <= 1'b0;
         o_io_clear <= 1'b0;
         o_start_addr <= '0;
         o_single_instruction_key_word <= '0;
      end else begin
         o_start <= go_start; // see R1
         o_resume <= go_resume; // see R5
         o_single_single_instruction_key <= go_single_instruction_key;
         o_io_clear <= go_ioclr; // see R14
         if (go_start) begin
            o_start_addr <= address_switch_reg;
         end
         if (go_single_instruction_key) begin
            o_single_instruction_key_word <= ds; // see R11
         end
      end
   end

   // console execute: no normal count, one skip count at most, jump saves pc as is
   assign o_console_single_instruction_key = state == CCK_SINGLE_INSTRUCTION_KEY; // see R12 see R13

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_bootstrap_mode_flag <= 1'b0;
      end else if (go_start) begin
         o_bootstrap_mode_flag <= trg[cck_pkg::K_BOOT]; // see R2
      end else if (go_ioclr || (i_fetch && i_fetch_addr > cck_pkg::BOOT_TOP_ADDR)) begin
         o_bootstrap_mode_flag <= 1'b0; // see R3
      end
   end

   assign o_fast_mem_disable = o_bootstrap_mode_flag; // see R2
   assign o_hidden_core_sel = o_bootstrap_mode_flag
                              && i_mem_addr <= cck_pkg::BOOT_TOP_ADDR; // see R2

   // set by a new call wins over a memory resume in the same cycle
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_memory_break_flag <= 1'b0;
      end else if (i_mem_call && lvl[cck_pkg::K_MSTEP]) begin
         o_memory_break_flag <= 1'b1; // see R7
      end else if (go_ioclr || (trg[cck_pkg::K_MRESUME] && o_memory_break_flag)) begin
         o_memory_break_flag <= 1'b0; // see R10
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_restart_key <= 1'b0;
      end else begin
         mem_restart_key <= trg[cck_pkg::K_MRESUME] && o_memory_break_flag; // see R10
      end
   end

   assign o_mem_restart = (i_mem_done && !o_memory_break_flag) || mem_restart_key; // see R8
   assign o_read_only_rpw = lvl[cck_pkg::K_MSTEP]; // see R9

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_key_mem_req <= 1'b0;
         o_key_write <= 1'b0;
         o_key_load_ma <= 1'b0;
         o_key_addr <= '0;
         o_key_wdata <= '0;
      end else begin
         o_key_mem_req <= go_mem;
         o_key_load_ma <= go_mem && !o_run; // see R15 see R16
         if (go_mem) begin
            o_key_write <= mem_wr;
            o_key_addr <= mem_addr;
            o_key_wdata <= ds; // see R15
         end
      end
   end

   // display: key accesses always, processor accesses only at the switch address
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_display <= cck_pkg::DISPLAY_RST;
      end else if (state == CCK_MEM && i_key_mem_done) begin
         o_mem_display <= o_key_write ? o_key_wdata : i_mem_rdata; // see R17
      end else if (i_mem_done && i_mem_addr == address_switch_reg) begin
         o_mem_display <= i_mem_write ? i_mem_wdata : i_mem_rdata; // see R18
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_input_word <= '0;
      end else if (i_input_word_instr) begin
         o_input_word <= ds; // see R19
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reader_motor <= 1'b0;
         o_reader_brake <= 1'b0;
      end else if (trg[cck_pkg::K_RDR_ON]) begin
         o_reader_motor <= 1'b1; // see R23
         o_reader_brake <= 1'b1;
      end else if (trg[cck_pkg::K_RDR_OFF]) begin
         o_reader_motor <= 1'b0; // see R23
         o_reader_brake <= 1'b0;
      end
   end

   // channel 1 is bit 0; channel 0 means the reader is unassigned
   assign rdr_req = (i_reader_chan != 3'h0
                     && (trg[cck_pkg::K_RDR_ON] || trg[cck_pkg::K_RDR_OFF]))
                    ? 7'((8'h1 << i_reader_chan) >> 1) : 7'h0; // see R23

   cck_pi #(
      .C (cck_pkg::CHANS)
   ) u_pi (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_clear     (go_ioclr),
      .i_enable    (i_interrupt_system_enabled),
      .i_on_wr     (i_pi_on_wr),
      .i_on_wdata  (i_pi_on_wdata),
      .i_prog_req  (i_pi_prog_req),
      .i_dev_req   (i_pi_dev_req | rdr_req),
      .i_break     (i_pi_break),
      .i_break_iot (i_io_transfer_instr),
      .i_dismiss   (i_pi_dismiss),
      .o_on        (o_channel_on_bits),
      .o_req       (o_channel_request_bits),
      .o_hold      (o_channel_hold_bits),
      .o_grant     (o_pi_grant)
   );

   start_run_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R1
      (trg[cck_pkg::K_START] && idle && !o_run && !lvl[cck_pkg::K_HALT])
      |=> o_run && o_start && o_start_addr == $past(address_switch_reg))
      else $error("start key did not start at switch address");
   boot_leave_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R3
      (i_fetch && i_fetch_addr > cck_pkg::BOOT_TOP_ADDR && !go_start)
      |=> !o_bootstrap_mode_flag)
      else $error("bootstrap mode kept after high fetch");
   break_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R8
      (o_memory_break_flag && !mem_restart_key) |-> !o_mem_restart)
      else $error("restart sent while memory break set");
   mem_resume_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R10
      (trg[cck_pkg::K_MRESUME] && o_memory_break_flag && !i_mem_call)
      |=> !o_memory_break_flag && o_mem_restart)
      else $error("memory resume did not restart");
   halt_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R4
      (lvl[cck_pkg::K_HALT] && !go_start && !go_resume) |=> !o_run)
      else $error("run stayed set under halt key");
endmodule
`default_nettype wire

// ### hdl/cck_key_sync.sv
// key synchroniser, edge detector and repeat generator
`timescale 1ns/1ps
`default_nettype none
module cck_key_sync #(
   parameter int N   = cck_pkg::NKEYS,
   parameter int REP = cck_pkg::REPEAT_CYCLES
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic [N-1:0] i_keys,
   input  wire logic         i_repeat,
   output logic      [N-1:0] o_level,
   output logic      [N-1:0] o_trig
);
   logic [N:0] meta;
   logic [N:0] sync;
   logic [N-1:0] prev;
   logic [15:0] rep_cnt;
   logic rep_tick;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= {i_repeat, i_keys};
         sync <= meta;
         prev <= sync[N-1:0];
      end
   end

   // one shared interval timer: keys held together repeat in step
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rep_cnt <= '0;
      end else if (!sync[N] || sync[N-1:0] == '0 || rep_tick) begin
         rep_cnt <= '0;
      end else begin
         rep_cnt <= rep_cnt + 16'h1;
      end
   end

   assign rep_tick = rep_cnt == 16'(REP - 1);
   assign o_level = sync[N-1:0];
   assign o_trig = (sync[N-1:0] & ~prev) | (rep_tick ? sync[N-1:0] : '0); // see R24

   one_press_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R24
      (!sync[N] && o_trig[0]) |=> !o_trig[0])
      else $error("key trigger repeated without repeat");
endmodule
`default_nettype wire

// ### hdl/cck_pi.sv
// interrupt channel on, request and hold bits
`timescale 1ns/1ps
`default_nettype none
module cck_pi #(
   parameter int C = cck_pkg::CHANS
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_clear,
   input  wire logic         i_enable,
   input  wire logic         i_on_wr,
   input  wire logic [C-1:0] i_on_wdata,
   input  wire logic [C-1:0] i_prog_req,
   input  wire logic [C-1:0] i_dev_req,
   input  wire logic         i_break,
   input  wire logic         i_break_iot,
   input  wire logic         i_dismiss,
   output logic      [C-1:0] o_on,
   output logic      [C-1:0] o_req,
   output logic      [C-1:0] o_hold,
   output logic      [C-1:0] o_grant
);
   function automatic logic [C-1:0] lowest(input logic [C-1:0] x);
      lowest = x & (~x + C'(1));
   endfunction

   logic [C-1:0] below;
   logic [C-1:0] set_req;
   logic [C-1:0] take;

   // only channels numbered below the lowest hold may break in
   assign below = (o_hold == '0) ? '1 : lowest(o_hold) - C'(1); // see R21
   assign o_grant = i_enable ? lowest(o_req & below) : '0; // see R21
   assign set_req = (i_prog_req | (i_dev_req & o_on)) & ~o_hold; // see R20
   assign take = i_break ? o_grant : '0;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_on <= '0;
      end else if (i_clear) begin
         o_on <= '0;
      end else if (i_on_wr) begin
         o_on <= i_on_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_req <= '0;
      end else if (i_clear) begin
         o_req <= '0;
      end else begin
         o_req <= (o_req & ~take) | (set_req & ~take); // see R21
      end
   end

   // a transfer instruction drops the request and leaves the hold unset
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hold <= '0;
      end else if (i_clear) begin
         o_hold <= '0;
      end else begin
         o_hold <= (o_hold & ~(i_dismiss ? lowest(o_hold) : '0))
                   | (i_break_iot ? '0 : take); // see R22
      end
   end

   gated_req_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R20
      (i_prog_req == '0 && !i_clear) |=> ((o_req & ~$past(o_req) & ~$past(o_on)) == '0))
      else $error("request set on a channel that is off");
   iot_nohold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R22
      (i_break && i_break_iot && !i_dismiss && !i_clear) |=> o_hold == $past(o_hold))
      else $error("hold stuck after transfer instruction");
   hold_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see R21
      (i_break && !i_break_iot && o_grant != '0 && !i_clear)
      |=> (lowest(o_hold) == $past(o_grant)) && !o_req[$clog2($past(o_grant))])
      else $error("hold not taken by lowest channel");
endmodule
`default_nettype wire

// ### hdl/cck_pkg.sv
// constants shared by the console key control block
// Notes on behaviour
// R1: start key works only when stopped; sets run, fetches first from address switches.
// R2: bootstrap start acts as start and sets bootstrap mode remapping low addresses.
// R3: bootstrap mode ends on any instruction fetch above address 17 octal.
// R4: halt key clears run; processor stops after the current instruction.
// R5: resume key works only when stopped; sets run, continues at program counter.
// R6: halt held plus resume press runs one instruction; repeat runs them at rate.
// R7: memory step held sets memory break flag at every memory subroutine start.
// R8: memory break flag withholds the restart pulse after the access completes.
// R9: memory stepping turns fetch read-pause-write into read, then separate write.
// R10: memory resume works only with break flag set; clears it and restarts.
// R11: single instruction key runs data switch word once, no program count.
// R12: a skip from the console increments the program counter at most once.
// R13: a console jump saves the program counter without incrementing it first.
// R14: io clear works only when stopped; clears flags, control state and bus gear.
// R15: store-here writes data switches at address switches and shows the word.
// R16: store-following works only when stopped; writes at access location plus one.
// R17: inspect-here reads address switches; inspect-following reads location plus one.
// R18: any access to the address switch location updates the memory display.
// R19: the program can read the 36-bit data switch word with an input word.
// R20: program requests set any channel; other requests need the channel on.
// R21: lower channels win; holds only set below lowest hold; hold blocks request.
// R22: holds stick only for non-transfer instructions; block transfer just drops request.
// R23: reader on and off keys drive motor and brake and raise reader request.
// R24: each key is synchronised and edge detected; one press makes one trigger.
package cck_pkg;
   localparam int ADDR_W = 18;
   localparam int WORD_W = 36;
   localparam int CHANS = 7;
   localparam int NKEYS = 14;
   localparam logic [17:0] BOOT_TOP_ADDR = 18'h0000f;
   localparam int CLK_NS = 10;
   localparam int REPEAT_NS = 3400;
   localparam int REPEAT_CYCLES = (REPEAT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic RUN_RST = 1'b0;
   localparam logic [35:0] DISPLAY_RST = 36'h0;
   // key positions in the key vector
   localparam int K_START = 0;
   localparam int K_BOOT = 1;
   localparam int K_HALT = 2;
   localparam int K_RESUME = 3;
   localparam int K_MSTEP = 4;
   localparam int K_MRESUME = 5;
   localparam int K_SINGLE_INSTRUCTION_KEY = 6;
   localparam int K_IOCLR = 7;
   localparam int K_DEP = 8;
   localparam int K_DEPNXT = 9;
   localparam int K_EX = 10;
   localparam int K_EXNXT = 11;
   localparam int K_RDR_ON = 12;
   localparam int K_RDR_OFF = 13;
endpackage

// ### verif/cck_console_tb.sv
// self-checking bench for the console key control block
`timescale 1ns/1ps
`default_nettype none
module cck_console_tb;
   logic        i_ref_clk, i_rst_n, i_repeat, i_inst_done, i_fetch, i_mem_call, i_mem_write;
   logic        i_mem_done, i_key_mem_done, i_input_word_instr, i_interrupt_system_enabled;
   logic        i_pi_on_wr, i_pi_break, i_io_transfer_instr, i_pi_dismiss, o_run, o_start;
   logic        o_resume, o_single_single_instruction_key, o_console_single_instruction_key, o_bootstrap_mode_flag, o_key_write;
   logic        o_fast_mem_disable, o_hidden_core_sel, o_memory_break_flag, o_mem_restart;
   logic        o_read_only_rpw, o_key_mem_req, o_reader_motor, o_reader_brake;
   logic [13:0] i_keys;
   logic [35:0] i_data_switch_reg, i_mem_wdata, i_mem_rdata, o_single_instruction_key_word, o_key_wdata;
   logic [35:0] o_mem_display, o_input_word;
   logic [17:0] i_address_switch_reg, i_fetch_addr, i_mem_addr, i_ma, o_start_addr, o_key_addr;
   logic [2:0]  i_reader_chan;
   logic [6:0]  i_pi_on_wdata, i_pi_prog_req, i_pi_dev_req, o_channel_on_bits;
   logic [6:0]  o_channel_request_bits, o_channel_hold_bits, o_pi_grant;
   logic        o_io_clear, o_key_load_ma;
   int          fails, n_compared, n_st, n_rs, n_rt, n_ld, n_io, n_cx, cyc;
   cck_console #(.REPEAT_CYC(4)) uut (.*);
   cck_proc_model #(.LAT(2)) proc (.i_ref_clk, .i_rst_n, .i_key_req(o_key_mem_req),
      .i_single_instruction_key(o_single_single_instruction_key | o_resume), .i_mem_done, .o_key_done(i_key_mem_done),
      .i_addr(i_key_mem_done ? o_key_addr : i_mem_addr), .o_inst_done(i_inst_done),
      .o_rdata(i_mem_rdata));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      if (o_start === 1'b1) n_st++;
      if (o_resume === 1'b1) n_rs++;
      if (o_mem_restart === 1'b1) n_rt++;
      if (o_key_load_ma === 1'b1) n_ld++;
      if (o_io_clear === 1'b1) n_io++;
      if (o_console_single_instruction_key === 1'b1) n_cx++;
      cyc++;
      if (cyc == 4000) begin
         fails++;
         final_report();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [35:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // keys pass a two-stage synchroniser, so hold well past three edges
   task automatic press(input int k);
      i_keys[k] = 1'b1;
      tick(8);
      i_keys[k] = 1'b0;
      tick(8);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_run();
      int s0;
      i_address_switch_reg = 18'h00123;
      press(cck_pkg::K_START);
      chk("start", {o_run, o_start_addr}, 36'h40123);
      s0 = n_st;
      press(cck_pkg::K_START);
      chk("start_again", n_st - s0, 36'h0);
      i_keys[cck_pkg::K_HALT] = 1'b1;
      tick(6);
      chk("halt", o_run, 36'h0);
      s0 = n_rs;
      press(cck_pkg::K_RESUME);
      chk("step", {n_rs - s0 == 1, o_run}, 36'h2);
      // repeat at four cycles: a hold of twenty gives several steps
      i_repeat = 1'b1;
      s0 = n_rs;
      i_keys[cck_pkg::K_RESUME] = 1'b1;
      tick(20);
      i_keys[cck_pkg::K_RESUME] = 1'b0;
      i_repeat = 1'b0;
      tick(4);
      chk("repeat", {n_rs - s0 >= 4, o_run}, 36'h2);
      i_keys[cck_pkg::K_HALT] = 1'b0;
      press(cck_pkg::K_RESUME);
      chk("resume", o_run, 36'h1);
      press(cck_pkg::K_HALT);
   endtask
   task automatic t_boot();
      press(cck_pkg::K_BOOT);
      i_mem_addr = 18'h0000f;
      tick(1);
      chk("boot", {o_bootstrap_mode_flag, o_fast_mem_disable, o_run}, 36'h7);
      chk("low", o_hidden_core_sel, 36'h1);
      i_fetch_addr = 18'h0000f;
      pulse(i_fetch);
      chk("boot_stay", o_bootstrap_mode_flag, 36'h1);
      i_fetch_addr = 18'h00010;
      pulse(i_fetch);
      chk("boot_end", o_bootstrap_mode_flag, 36'h0);
      press(cck_pkg::K_HALT);
   endtask
   task automatic t_mstep();
      int s0;
      i_keys[cck_pkg::K_MSTEP] = 1'b1;
      tick(4);
      pulse(i_mem_call);
      chk("mbrk", {o_memory_break_flag, o_read_only_rpw}, 36'h3);
      s0 = n_rt;
      pulse(i_mem_done);
      chk("held", n_rt - s0, 36'h0);
      i_keys[cck_pkg::K_MSTEP] = 1'b0;
      press(cck_pkg::K_MRESUME);
      chk("mres", {o_memory_break_flag, n_rt - s0 == 1}, 36'h1);
   endtask
   task automatic t_key();
      i_ma = 18'h00200;
      i_address_switch_reg = 18'h00040;
      i_data_switch_reg = 36'habcdef012;
      press(cck_pkg::K_SINGLE_INSTRUCTION_KEY);
      chk("single_instruction_key", o_single_instruction_key_word, 36'habcdef012);
      chk("single_instruction_key_run", o_run, 36'h0);
      chk("cexec", n_cx, 36'h3);
      press(cck_pkg::K_DEP);
      chk("dep", {o_key_write, o_key_addr}, 36'h40040);
      chk("dep_data", o_key_wdata, 36'habcdef012);
      chk("dep_show", o_mem_display, 36'habcdef012);
      press(cck_pkg::K_DEPNXT);
      chk("depnxt", {o_key_write, o_key_addr}, 36'h40201);
      press(cck_pkg::K_EXNXT);
      chk("exnxt", o_mem_display, {18'h00201, 18'h3fdfe});
      chk("load_ma", n_ld, 36'h3);
      i_mem_addr = 18'h00040;
      pulse(i_mem_call);
      pulse(i_mem_done);
      chk("show_rd", o_mem_display, {18'h00040, 18'h3ffbf});
      i_mem_write = 1'b1;
      i_mem_wdata = 36'h123456789;
      pulse(i_mem_done);
      i_mem_write = 1'b0;
      chk("show_wr", o_mem_display, 36'h123456789);
      pulse(i_input_word_instr);
      chk("inword", o_input_word, 36'habcdef012);
   endtask
   task automatic t_pi();
      i_pi_on_wdata = 7'h03;
      pulse(i_pi_on_wr);
      i_pi_dev_req = 7'h05;
      i_pi_prog_req = 7'h08;
      tick(1);
      i_pi_dev_req = 7'h00;
      i_pi_prog_req = 7'h00;
      tick(1);
      chk("req", o_channel_request_bits, 36'h09);
      i_reader_chan = 3'h2;
      press(cck_pkg::K_RDR_ON);
      chk("rdr", {o_reader_motor, o_reader_brake, o_channel_request_bits}, 36'h18b);
      i_interrupt_system_enabled = 1'b1;
      i_io_transfer_instr = 1'b1;
      tick(1);
      chk("grant", o_pi_grant, 36'h01);
      pulse(i_pi_break);
      chk("iot", {o_channel_hold_bits, o_channel_request_bits}, 36'h00a);
      i_io_transfer_instr = 1'b0;
      pulse(i_pi_break);
      chk("hold", {o_channel_hold_bits, o_channel_request_bits, o_pi_grant}, 36'h8400);
      pulse(i_pi_dismiss);
      chk("dismiss", {o_channel_hold_bits, o_pi_grant}, 36'h008);
      press(cck_pkg::K_IOCLR);
      chk("ioclr", {o_channel_on_bits, o_channel_request_bits}, 36'h0);
      chk("io_pulse", n_io, 36'h1);
   endtask
   initial begin
      {i_rst_n, i_repeat, i_fetch, i_mem_call, i_mem_write, i_mem_done, i_input_word_instr,
       i_interrupt_system_enabled, i_pi_on_wr, i_pi_break, i_io_transfer_instr, i_pi_dismiss,
       i_keys, i_data_switch_reg, i_mem_wdata, i_address_switch_reg, i_fetch_addr, i_mem_addr,
       i_ma, i_reader_chan, i_pi_on_wdata, i_pi_prog_req, i_pi_dev_req} = '0;
      tick(6);
      i_rst_n = 1'b1;
      tick(2);
      t_run();
      t_boot();
      t_mstep();
      t_key();
      t_pi();
      final_report();
   end
endmodule
`default_nettype wire

// ### verif/cck_proc_model.sv
// stand-in for the processor main sequence and memory subroutine
`timescale 1ns/1ps
`default_nettype none
module cck_proc_model #(
   parameter int LAT = 2
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_key_req,
   input  wire logic        i_single_instruction_key,
   input  wire logic        i_mem_done,
   input  wire logic [17:0] i_addr,
   output logic             o_key_done,
   output logic             o_inst_done,
   output logic [35:0]      o_rdata
);
   logic [7:0]  kpipe, ipipe;
   logic [35:0] last;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         kpipe <= '0;
         ipipe <= '0;
         last <= '0;
      end else begin
         kpipe <= {kpipe[6:0], i_key_req};
         ipipe <= {ipipe[6:0], i_single_instruction_key};
         if (o_key_done || i_mem_done) last <= o_rdata;
      end
   end
   assign o_key_done = kpipe[LAT-1];
   assign o_inst_done = ipipe[LAT-1];
   // a word reads as its address and inverse; idle bus shows no stale copy
   assign o_rdata = (o_key_done || i_mem_done) ? {i_addr, ~i_addr} : ~last;
endmodule
`default_nettype wire
